// ==== hw/lsp_top.sv ====
// Serial load port with configuration and display registers and bank scan timing
`timescale 1ns/1ps
`default_nettype none
module lsp_top #(
    parameter int unsigned BANK_PERIOD = lsp_pkg::BANK_CYCLES,
    parameter int unsigned BLANK_PERIOD = lsp_pkg::BLANK_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic sel_b,
    input wire logic sdata_in,
    output logic sdata_out,
    output logic [lsp_pkg::CFG_BITS-1:0] cfg_reg,
    output logic [lsp_pkg::DISP_BITS-1:0] disp_reg,
    output logic blank,
    output logic [lsp_pkg::BANKS-1:0] bank_on,
    output logic full_current,
    output logic soft_reset_b
);
    import lsp_pkg::*;

    // The blanking and scan counters are 16 and 18 bits wide
    if (BANK_PERIOD < 2 || BANK_PERIOD > 32'h0003FFFF || BLANK_PERIOD < 1 ||
        BLANK_PERIOD > 32'h0000FFFF)
    begin : g_bad_period
        $error("lsp_top: period parameters out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the serial clock is sampled, not used as a clock
    logic sclk_s;
    logic sel_s;
    logic din_s;

    lsp_sync u_sync_clk (.mclk(mclk), .rst_b(rst_b), .async_in(sclk), .reset_val(1'b0),
        .sync_out(sclk_s));
    lsp_sync u_sync_sel (.mclk(mclk), .rst_b(rst_b), .async_in(sel_b), .reset_val(1'b1),
        .sync_out(sel_s));
    lsp_sync u_sync_din (.mclk(mclk), .rst_b(rst_b), .async_in(sdata_in), .reset_val(1'b0),
        .sync_out(din_s));

    logic sclk_d1_q;
    logic sel_d1_q;
    logic sclk_rise;
    logic sclk_fall;
    logic sel_rise;

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            sclk_d1_q <= 1'b0;
            sel_d1_q <= 1'b1;
        end
        else
        begin
            sclk_d1_q <= sclk_s;
            sel_d1_q <= sel_s;
        end
    end

    // Data is delayed like the clock, so both keep their pin-level relation
    assign sclk_rise = sclk_s && !sclk_d1_q;
    assign sclk_fall = !sclk_s && sclk_d1_q;
    assign sel_rise = sel_s && !sel_d1_q;

    ////////////////////////////////////////////////////////////////////////
    // Port state: armed only after select high with clock low
    // Lost state is left only once select is high with the clock low
    typedef enum logic [1:0] {
        LSP_IDLE = 2'b00,
        LSP_SHIFT = 2'b01,
        LSP_LOST = 2'b10
    } lsp_state_t;

    lsp_state_t state_q;

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            state_q <= LSP_LOST;
        else
        begin
            case (state_q)
                LSP_LOST:
                    if (sel_s && !sclk_s)
                        state_q <= LSP_IDLE;
                LSP_IDLE:
                    if (!sel_s)
                        state_q <= sclk_s ? LSP_LOST : LSP_SHIFT;
                LSP_SHIFT:
                    if (sel_s)
                        state_q <= sclk_s ? LSP_LOST : LSP_IDLE;
                default:
                    state_q <= LSP_LOST;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Static shift register: 24 full stages plus a half stage on the fall
    logic [DISP_BITS-1:0] shift_q;
    logic half_q;
    logic [CNT_W-1:0] count_q;
    logic shifting;

    assign shifting = (state_q == LSP_SHIFT) && !sel_s;

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            shift_q <= DISP_RESET;
        else if (shifting && sclk_rise)
            shift_q <= {shift_q[DISP_BITS-2:0], din_s};
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b || sel_s)
            half_q <= 1'b0;
        else if (shifting && sclk_fall)
            half_q <= shift_q[DISP_BITS-1];
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b || state_q == LSP_IDLE)
            count_q <= '0;
        else if (shifting && sclk_rise && count_q != CNT_MAX)
            count_q <= count_q + 6'h01;
    end

    assign sdata_out = half_q;

    ////////////////////////////////////////////////////////////////////////
    // Register load on select rising edge
    logic load_ok;
    logic blank_start;
    logic [CFG_BITS-1:0] cfg_q;
    logic [DISP_BITS-1:0] disp_q;

    // Chained lengths leave this device's share in the low bits of the shift stages
    assign load_ok = (state_q == LSP_SHIFT) && sel_rise && !sclk_s;
    // Every select rise blanks, even for a refused length or a lost frame
    assign blank_start = sel_rise;

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            cfg_q <= CFG_RESET;
        else if (load_ok && (count_q == CFG_LEN || count_q == CFG_LEN + DISP_LEN))
            cfg_q <= shift_q[CFG_BITS-1:0];
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            disp_q <= DISP_RESET;
        else if (load_ok && (count_q == DISP_LEN || count_q == DISP_LEN + DISP_LEN))
            disp_q <= shift_q;
    end

    assign cfg_reg = cfg_q;
    assign disp_reg = disp_q;
    assign full_current = disp_q[BRIGHT_POS];
    assign soft_reset_b = cfg_q[SOFT_RESET_POS];

    ////////////////////////////////////////////////////////////////////////
    // Blanking interval and bank scan
    logic [15:0] blank_cnt_q;
    logic [17:0] tick_cnt_q;
    logic [BANKS-1:0] bank_q;
    logic blank_d;
    logic blank_q;
    logic [BANKS-1:0] bank_on_q;

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            blank_cnt_q <= 16'h0000;
        else if (blank_start)
            blank_cnt_q <= BLANK_PERIOD[15:0];
        else if (blank_cnt_q != 16'h0000)
            blank_cnt_q <= blank_cnt_q - 16'h0001;
    end

    assign blank_d = (blank_cnt_q != 16'h0000) || !soft_reset_b;

    always_ff @(posedge mclk)
    begin
        if (!rst_b || !soft_reset_b)
        begin
            tick_cnt_q <= 18'h00000;
            bank_q <= 5'h01;
        end
        else if (tick_cnt_q == BANK_PERIOD[17:0] - 18'h00001)
        begin
            tick_cnt_q <= 18'h00000;
            bank_q <= {bank_q[BANKS-2:0], bank_q[BANKS-1]};
        end
        else
            tick_cnt_q <= tick_cnt_q + 18'h00001;
    end

    // Registered so blank and the bank drivers switch on the same edge
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            blank_q <= 1'b1;
            bank_on_q <= '0;
        end
        else
        begin
            blank_q <= blank_d;
            bank_on_q <= blank_d ? '0 : bank_q;
        end
    end

    assign blank = blank_q;
    assign bank_on = bank_on_q;
endmodule
`default_nettype wire

// ==== hw/lsp_pkg.sv ====
// Constants for the serial load port of the LED display driver
// How it works
// - Word arrives most significant bit first, sampled on serial clock rising edge.
// - One device: eight clocks load configuration, twenty-four clocks load display.
// - Two chained devices need thirty-two or forty-eight clocks respectively.
// - Loaded registers change only when select rises; shifting leaves them alone.
// - Data output advances from the shift register on serial clock falling edge.
// - Static shift register of twenty-four and a half stages holds with clock stopped.
// - Serial capture works with a clock unrelated to the multiplex oscillator.
// - Select high forces data output low, ignores clocks, holds port initialised.
// - Select rising edge copies shifted bits to a register chosen by bit count.
// - Every select rising edge starts a blanking interval, even for equal data.
// - Port regains known state whenever select is high and clock is low.
// - Soft-reset bit written low then high reinitialises the device; here it only blanks and restarts the bank scan, registers kept.
// - No address bits; every streamed bit is register data, any order.
// - Data output carries shifted bits ready for the next device in a chain.
// - Five cathode banks scanned at a refresh rate between 700 and 1900 Hz.
// - Top display bit high selects full current, low selects about half.
// - Nominal 1 kHz refresh, each bank active one fifth of the cycle.
package lsp_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned CFG_BITS = 8;
    localparam int unsigned DISP_BITS = 24;
    localparam int unsigned CNT_W = 6;
    localparam logic [CNT_W-1:0] CFG_LEN = 6'h08;
    localparam logic [CNT_W-1:0] DISP_LEN = 6'h18;
    localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;
    localparam logic [CFG_BITS-1:0] CFG_RESET = 8'h00;
    localparam logic [DISP_BITS-1:0] DISP_RESET = 24'h000000;
    localparam int unsigned SOFT_RESET_POS = 0;
    localparam int unsigned BRIGHT_POS = 23;
    localparam int unsigned BANKS = 5;
    localparam int unsigned REFRESH_HZ = 1000;
    localparam int unsigned BANK_CYCLES = CLK_HZ / (REFRESH_HZ * BANKS);
    localparam int unsigned BLANK_NS = 50_000;
    localparam int unsigned BLANK_CYCLES = (BLANK_NS * 40 + 999) / 1000;
endpackage

// ==== hw/lsp_sync.sv ====
// Two-flop synchroniser for one input pin
`timescale 1ns/1ps
`default_nettype none
module lsp_sync (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic async_in,
    input wire logic reset_val,
    output var logic sync_out
);
    logic meta_q;
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            meta_q <= reset_val;
            sync_out <= reset_val;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== verif/lsp_checker_assertions.sv ====
// Concurrent checks on the serial load port pins
`timescale 1ns/1ps
`default_nettype none
module lsp_checker #(
    parameter int unsigned BANK_PERIOD = 10,
    parameter int unsigned BLANK_PERIOD = 4
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic sel_b,
    input wire logic sdata_in,
    input wire logic sdata_out,
    input wire logic [lsp_pkg::CFG_BITS-1:0] cfg_reg,
    input wire logic [lsp_pkg::DISP_BITS-1:0] disp_reg,
    input wire logic blank,
    input wire logic [lsp_pkg::BANKS-1:0] bank_on,
    input wire logic full_current,
    input wire logic soft_reset_b
);
    import lsp_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    out_idle_low_a: assert property (sel_b [*5] |-> !sdata_out)
        else $error("data out not low while deselected");
    // Sync delay is two cycles, so six quiet cycles rule out a late load
    hold_shift_a: assert property (!sel_b [*6] |=> $stable(disp_reg) && $stable(cfg_reg))
        else $error("register moved while shifting");
    bright_map_a: assert property (full_current == disp_reg[BRIGHT_POS])
        else $error("current select wrong");
    soft_map_a: assert property (soft_reset_b == cfg_reg[SOFT_RESET_POS])
        else $error("soft reset wrong");
    blank_dark_a: assert property (blank |-> bank_on == '0)
        else $error("bank on while blanked");
    one_bank_a: assert property (!blank |-> $onehot(bank_on))
        else $error("bank scan not one hot");
    load_blank_a: assert property ($rose(sel_b) && !sclk |-> ##[3:6] blank)
        else $error("no blanking after select rise");
    load_cause_a: assert property ($changed(disp_reg) || $changed(cfg_reg) |-> sel_b && $past(sel_b, 2))
        else $error("register changed without select rise");
endmodule
bind lsp_top lsp_checker #(.BANK_PERIOD(BANK_PERIOD), .BLANK_PERIOD(BLANK_PERIOD)) chk_i (
    .mclk(mclk), .rst_b(rst_b), .sclk(sclk), .sel_b(sel_b), .sdata_in(sdata_in),
    .sdata_out(sdata_out), .cfg_reg(cfg_reg), .disp_reg(disp_reg), .blank(blank),
    .bank_on(bank_on), .full_current(full_current), .soft_reset_b(soft_reset_b));
`default_nettype wire

// ==== verif/lsp_host_model.sv ====
// Host model driving select, serial clock and data
`timescale 1ns/1ps
`default_nettype none
module lsp_host_model (
    input wire logic mclk,
    output logic sclk,
    output logic sel_b,
    output logic sdata_in,
    input wire logic sdata_out
);
    // Bits seen on data out, sampled just before each rising clock
    logic [47:0] echo;
    initial
    begin
        sclk = 1'b0;
        sel_b = 1'b1;
        sdata_in = 1'b0;
        echo = 48'h000000000000;
    end
    // Serial clock is 200 ns and stands low between frames
    task automatic send(input logic [47:0] w, input int n, input bit slip);
        @(posedge mclk);
        // A slip drops select with the clock high, so the frame must be lost
        if (slip)
        begin
            sclk <= 1'b1;
            repeat (4) @(posedge mclk);
        end
        sel_b <= 1'b0;
        if (slip)
        begin
            repeat (4) @(posedge mclk);
            sclk <= 1'b0;
        end
        for (int i = n - 1; i >= 0; i--)
        begin
            sdata_in <= w[i];
            repeat (4) @(posedge mclk);
            echo <= {echo[46:0], sdata_out};
            sclk <= 1'b1;
            repeat (4) @(posedge mclk);
            sclk <= 1'b0;
        end
        repeat (4) @(posedge mclk);
        sel_b <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// ==== verif/led_driver_serial_load_port_tb.sv ====
// Self-checking bench for the serial load port
`timescale 1ns/1ps
`default_nettype none
module led_driver_serial_load_port_tb;
    import lsp_pkg::*;
    logic mclk, rst_b, sclk, sel_b, sdata_in, sdata_out, blank, full_current, soft_reset_b;
    logic [CFG_BITS-1:0] cfg_reg;
    logic [DISP_BITS-1:0] disp_reg;
    logic [BANKS-1:0] bank_on;
    int error_cnt = 0;
    int n_checks = 0;
    lsp_top #(.BANK_PERIOD(10), .BLANK_PERIOD(4)) uut (.mclk(mclk), .rst_b(rst_b),
        .sclk(sclk), .sel_b(sel_b), .sdata_in(sdata_in), .sdata_out(sdata_out),
        .cfg_reg(cfg_reg), .disp_reg(disp_reg), .blank(blank), .bank_on(bank_on),
        .full_current(full_current), .soft_reset_b(soft_reset_b));
    lsp_host_model host (.mclk(mclk), .sclk(sclk), .sel_b(sel_b), .sdata_in(sdata_in),
        .sdata_out(sdata_out));
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic load(input logic [47:0] w, input int n, input bit slip);
        host.send(w, n, slip);
        repeat (12) @(posedge mclk);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_single;
        load(48'hA5, 8, 0);
        chk("cfg", 48'hA5, cfg_reg);
        chk("blank", 48'h0, blank);
        load(48'h8C3A51, 24, 0);
        chk("disp", 48'h8C3A51, disp_reg);
        chk("full", 48'h1, full_current);
        chk("cfg kept", 48'hA5, cfg_reg);
        host.send(48'h8C3A51, 24, 0);
        @(posedge mclk);
        chk("blank", 48'h1, blank);
        chk("disp same", 48'h8C3A51, disp_reg);
        repeat (12) @(posedge mclk);
        $display("single loads done");
    endtask
    task automatic t_chain;
        load(48'hC35A96_0F1E2D, 48, 0);
        chk("disp", 48'h0F1E2D, disp_reg);
        chk("full", 48'h0, full_current);
        chk("data out", 48'hC35A96, host.echo[23:0]);
        load(48'hFFFFFF_3D, 32, 0);
        chk("cfg", 48'h3D, cfg_reg);
        $display("chained loads done");
    endtask
    task automatic t_odd;
        load(48'hABC, 12, 0);
        chk("cfg", 48'h3D, cfg_reg);
        chk("disp", 48'h0F1E2D, disp_reg);
        $display("odd length done");
    endtask
    task automatic t_slip;
        load(48'h11, 8, 1);
        chk("cfg", 48'h3D, cfg_reg);
        load(48'h81, 8, 0);
        chk("cfg", 48'h81, cfg_reg);
        $display("resync done");
    endtask
    task automatic t_soft;
        load(48'hA4, 8, 0);
        chk("blank", 48'h1, blank);
        chk("banks", 48'h0, bank_on);
        load(48'hA5, 8, 0);
        chk("blank", 48'h0, blank);
        chk("banks one hot", 48'h1, $onehot(bank_on));
        $display("soft reset done");
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        rst_b = 1'b0;
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (8) @(posedge mclk);
        t_single();
        t_chain();
        t_odd();
        t_slip();
        t_soft();
        end_sim();
    end
    // Scenarios need about 1700 cycles
    initial
    begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        end_sim();
    end
endmodule
`default_nettype wire
